// ### hdl/lis_top.sv
`timescale 1ns/1ns
`default_nettype none
module lis_top #(
	parameter int unsigned HALF_S    = lis_pkg::HALF_SLOW,
	parameter int unsigned HALF_M    = lis_pkg::HALF_MID,
	parameter int unsigned HALF_F    = lis_pkg::HALF_FAST,
	parameter int unsigned SHORT_C   = lis_pkg::SHORT_CYC,
	parameter int unsigned LONG_C    = lis_pkg::LONG_CYC,
	parameter int unsigned GAP_C     = lis_pkg::GAP_CYC,
	parameter logic [7:0]  MEM_ERROR = 8'he8
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// Identify sources
	input  wire logic              identify_button,
	input  wire logic              remote_identify_on,
	input  wire logic              remote_identify_off,
	// Management controller boot events
	input  wire logic              mc_reset_start,
	input  wire logic              mc_mem_test_fail,
	input  wire logic              mc_images_bad,
	input  wire logic              mc_os_handoff,
	input  wire logic              mc_boot_done,
	// System health
	input  wire logic              health_degraded,
	input  wire logic              health_fault,
	// Fault blink code request
	input  wire logic              code_req,
	input  wire lis_pkg::lis_code_t code_sel,
	// Progress display control
	input  wire logic              progress_write,
	input  wire logic [7:0]        progress_code,
	input  wire logic              self_test_complete,
	// Indicator outputs
	output logic                   identify_led,
	output logic                   status_green,
	output logic                   status_amber,
	output logic                   fault_blink_indicator,
	output logic [7:0]             progress_leds,
	// Status toward firmware
	output logic                   code_busy,
	output logic                   code_done,
	output logic                   system_halt
);
	import lis_pkg::*;

	// All block state in one record, rebuilt each cycle
	// Every output pin is a field here, so each comes from a flop
	// Boot patterns mask the identify mode but never clear it
	typedef struct packed {
		lis_id_t     id;      // Identify mode
		lis_boot_t   boot;    // Boot phase
		logic        req;     // Request to player
		logic [15:0] digits;  // Digits to player
		logic [2:0]  ndig;    // Digit count to player
		logic        halt;    // System halted
		logic [7:0]  prog;    // Progress LEDs shown
		logic        id_led;  // Identify output
		logic        green;   // Green output
		logic        amber;   // Amber output
		logic        fblink;  // Fault blink output
		logic        busy;    // Busy output
		logic        done;    // Done output
	} lis_top_t;

	// Reset value; the boot sequence starts at power-up
	localparam lis_top_t TOP_RESET = '{
		id: ID_OFF, boot: B_LOADER, req: 1'b0, digits: 16'h0,
		ndig: 3'h0, halt: 1'b0, prog: PROG_RESET,
		id_led: 1'b0, green: 1'b0, amber: 1'b0, fblink: 1'b0,
		busy: 1'b0, done: 1'b0
	};

	lis_top_t st, next_st;

	// Blink phases from the rate generator
	// Bit order follows the package phase positions
	logic [2:0] phase;

	// Link to the code player
	// Request in; busy, done and blink out
	lis_code_if code ();

	// Slow, mid and fast square waves
	lis_rate_gen #(
		.HALF_S (HALF_S),
		.HALF_M (HALF_M),
		.HALF_F (HALF_F)
	) u_rate (
		.clk     (clk),
		.reset_n (reset_n),
		.phase   (phase)
	);

	// Counted blink player
	lis_code_player #(
		.SHORT_C (SHORT_C),
		.LONG_C  (LONG_C),
		.GAP_C   (GAP_C)
	) u_player (
		.clk     (clk),
		.reset_n (reset_n),
		.code    (code)
	);

	// One digit field: long flag and count
	function automatic logic [3:0] dg(logic lng, logic [2:0] c);
		return {lng, c};
	endfunction

	// Digit pattern for each code, digit 0 lowest
	// Top three bits give the digit count; digit 0 plays first
	// Codes outside the table are not expected from firmware
	function automatic logic [18:0] pattern(lis_code_t c);
		case (c)
			LIS_USB:          return {3'h1, 12'h0, dg(1'b0, 3'h1)};
			LIS_SECURITY:     return {3'h1, 12'h0, dg(1'b1, 3'h1)};
			LIS_MEMORY:       return {3'h1, 12'h0, dg(1'b0, 3'h3)};
			LIS_CPU_MISMATCH: return {3'h2, 8'h0, dg(1'b0, 3'h1),
				dg(1'b1, 3'h3)};
			LIS_REC_START:    return {3'h1, 12'h0, dg(1'b0, 3'h2)};
			LIS_REC_FAIL:     return {3'h1, 12'h0, dg(1'b0, 3'h4)};
			LIS_1521: return {3'h4, dg(1'b0, 3'h1), dg(1'b0, 3'h2),
				dg(1'b0, 3'h5), dg(1'b0, 3'h1)};
			LIS_1524: return {3'h4, dg(1'b0, 3'h4), dg(1'b0, 3'h2),
				dg(1'b0, 3'h5), dg(1'b0, 3'h1)};
			LIS_1542: return {3'h4, dg(1'b0, 3'h2), dg(1'b0, 3'h4),
				dg(1'b0, 3'h5), dg(1'b0, 3'h1)};
			LIS_1544: return {3'h4, dg(1'b0, 3'h4), dg(1'b0, 3'h4),
				dg(1'b0, 3'h5), dg(1'b0, 3'h1)};
			LIS_1512: return {3'h4, dg(1'b0, 3'h2), dg(1'b0, 3'h1),
				dg(1'b0, 3'h5), dg(1'b0, 3'h1)};
			LIS_1514: return {3'h4, dg(1'b0, 3'h4), dg(1'b0, 3'h1),
				dg(1'b0, 3'h5), dg(1'b0, 3'h1)};
			default:  return 19'h0;
		endcase
	endfunction

	// Player inputs come from registers
	assign code.req    = st.req;
	assign code.digits = st.digits;
	assign code.ndig   = st.ndig;

	// Next state of the whole indicator block
	always_comb begin
		logic        take;     // Code request accepted
		logic [18:0] pat;      // Selected pattern
		logic        id_lvl;   // Normal identify level
		take   = 1'b0;
		pat    = pattern(code_sel);
		id_lvl = 1'b0;
		next_st = st;

		// Identify mode: newest request wins
		// Button toggles steady and off; remote blinks or clears
		if (identify_button) begin
			case (st.id)
				ID_OFF:    next_st.id = ID_STEADY;
				ID_STEADY: next_st.id = ID_OFF;
				ID_BLINK:  next_st.id = ID_STEADY;
				default:   next_st.id = ID_OFF;
			endcase
		end else if (remote_identify_on) begin
			next_st.id = ID_BLINK;
		end else if (remote_identify_off) begin
			next_st.id = ID_OFF;
		end

		// Boot phase tracking
		// Phase lengths are paced by firmware events, not timed
		// Failure phases are terminal; only a reset leaves them
		case (st.boot)
			B_LOADER: begin
				if (mc_mem_test_fail) begin
					next_st.boot = B_MEMFAIL;
				end else if (mc_images_bad) begin
					next_st.boot = B_IMGBAD;
				end else if (mc_os_handoff) begin
					next_st.boot = B_OS;
				end
			end
			B_OS: begin
				if (mc_mem_test_fail) begin
					next_st.boot = B_MEMFAIL;
				end else if (mc_boot_done) begin
					next_st.boot = B_NORMAL;
				end else if (mc_reset_start) begin
					next_st.boot = B_LOADER;
				end
			end
			B_NORMAL: begin
				// Update, cold reset or watchdog restarts it
				if (mc_reset_start) begin
					next_st.boot = B_LOADER;
				end
			end
			B_MEMFAIL: next_st.boot = B_MEMFAIL; // Not recoverable
			B_IMGBAD:  next_st.boot = B_IMGBAD;  // Not recoverable
			default:   next_st.boot = B_LOADER;
		endcase

		// Accept a code only while the player is idle
		// The in-flight flag covers the cycle before the player
		// reports busy, so one request is never taken twice
		next_st.req = 1'b0;
		if (code_req && !code.busy && !st.req) begin
			take = 1'b1;
			next_st.req    = 1'b1;
			next_st.ndig   = pat[18:16];
			next_st.digits = pat[15:0];
		end

		// Halting codes and their progress codes
		// A halt holds the display until reset, except that a later
		// halting code loads its own code; firmware writes are dropped
		if (take) begin
			case (code_sel)
				LIS_SECURITY: begin
					next_st.halt    = 1'b1;
					next_st.prog    = PROG_SECURITY;
				end
				LIS_MEMORY: begin
					next_st.halt    = 1'b1;
					next_st.prog    = MEM_ERROR;
				end
				LIS_CPU_MISMATCH: begin
					next_st.halt    = 1'b1;
					next_st.prog    = PROG_CPU;
				end
				default: next_st.halt = st.halt;
			endcase
		end else if (!st.halt) begin
			// Progress display follows firmware until a halt, except in a cycle that accepts a code
			if (progress_write) begin
				next_st.prog = progress_code;
			end else if (self_test_complete) begin
				// Blanked display keeps no stale code
				next_st.prog = 8'h00;
			end
		end

		// Identify level in normal operation
		case (st.id)
			ID_STEADY: id_lvl = 1'b1;
			ID_BLINK:  id_lvl = phase[PH_SLOW];
			default:   id_lvl = 1'b0;
		endcase

		// LED patterns by boot phase
		// Outside normal operation the boot pattern is shown; the
		// identify mode reappears once boot ends
		case (st.boot)
			B_MEMFAIL: begin
				next_st.id_led = 1'b1;
				next_st.amber  = 1'b1;
				next_st.green  = 1'b0;
			end
			B_IMGBAD: begin
				next_st.id_led = phase[PH_FAST];
				next_st.amber  = 1'b1;
				next_st.green  = 1'b0;
			end
			B_LOADER: begin
				next_st.id_led = phase[PH_MID];
				next_st.amber  = 1'b0;
				next_st.green  = phase[PH_SLOW];
			end
			B_OS: begin
				next_st.id_led = 1'b1;
				next_st.amber  = 1'b0;
				next_st.green  = 1'b1;
			end
			B_NORMAL: begin
				// Amber wins; degraded blinks green
				next_st.id_led = id_lvl;
				next_st.amber  = health_fault;
				next_st.green  = !health_fault &&
					(!health_degraded || phase[PH_SLOW]);
			end
			default: begin
				next_st.id_led = 1'b0;
				next_st.amber  = 1'b0;
				next_st.green  = 1'b0;
			end
		endcase

		// Registered copies of player outputs
		next_st.fblink = code.led;
		// Busy spans the request cycle and the whole playback
		next_st.busy   = code.busy || st.req || next_st.req;
		next_st.done   = code.done;
	end

	// State register
	// Synchronous reset; its release starts the boot sequence
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st <= TOP_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register
	assign identify_led          = st.id_led;
	assign status_green          = st.green;
	assign status_amber          = st.amber;
	assign fault_blink_indicator = st.fblink;
	// Latest progress code, blank after self test, until a halting code loads its own
	assign progress_leds         = st.prog;
	assign code_busy             = st.busy;
	assign code_done             = st.done;
	assign system_halt           = st.halt;
endmodule
`default_nettype wire

// ### common/lis_pkg.sv
`default_nettype none
package lis_pkg;
	// System clock rate
	localparam int unsigned CLK_HZ = 25_000_000;
	// Blink rates in hertz
	localparam int unsigned RATE_SLOW_HZ = 1;
	localparam int unsigned RATE_MID_HZ  = 3;
	localparam int unsigned RATE_FAST_HZ = 6;
	// Half periods in cycles, 50 percent duty
	localparam int unsigned HALF_SLOW = CLK_HZ / (2 * RATE_SLOW_HZ);
	localparam int unsigned HALF_MID  = CLK_HZ / (2 * RATE_MID_HZ);
	localparam int unsigned HALF_FAST = CLK_HZ / (2 * RATE_FAST_HZ);
	// Code blink timing in milliseconds
	localparam int unsigned SHORT_MS = 250;
	localparam int unsigned LONG_MS  = 750;
	localparam int unsigned GAP_MS   = 1000;
	localparam int unsigned SHORT_CYC = (CLK_HZ / 1000) * SHORT_MS;
	localparam int unsigned LONG_CYC  = (CLK_HZ / 1000) * LONG_MS;
	localparam int unsigned GAP_CYC   = (CLK_HZ / 1000) * GAP_MS;
	// Phase vector bit positions
	localparam int PH_SLOW = 0;
	localparam int PH_MID  = 1;
	localparam int PH_FAST = 2;
	// Digit field layout: {long, count[2:0]}, digit 0 lowest
	localparam int DIG_W    = 4;
	localparam int DIG_N    = 4;
	localparam int DIG_LONG = 3;
	// Fixed progress codes shown on halts and at reset
	localparam logic [7:0] PROG_SECURITY = 8'hae;
	localparam logic [7:0] PROG_CPU      = 8'he5;
	localparam logic [7:0] PROG_RESET    = 8'h00;
	// Fault blink codes selectable by firmware
	typedef enum logic [3:0] {
		LIS_USB, LIS_SECURITY, LIS_MEMORY, LIS_CPU_MISMATCH,
		LIS_REC_START, LIS_REC_FAIL, LIS_1521, LIS_1524,
		LIS_1542, LIS_1544, LIS_1512, LIS_1514
	} lis_code_t;
	// Management controller boot phases
	typedef enum logic [2:0] {
		B_MEMFAIL, B_IMGBAD, B_LOADER, B_OS, B_NORMAL
	} lis_boot_t;
	// Identify LED modes
	typedef enum logic [1:0] {ID_OFF, ID_STEADY, ID_BLINK} lis_id_t;
endpackage
`default_nettype wire

// ### common/lis_code_if.sv
`timescale 1ns/1ns
`default_nettype none
interface lis_code_if;
	logic        req;     // Start a code, one cycle
	logic [15:0] digits;  // Four digit fields
	logic [2:0]  ndig;    // Digits in use
	logic        busy;    // Player running
	logic        done;    // Code finished, one cycle
	logic        led;     // Blink output
	modport src (output req, digits, ndig, input busy, done, led);
	modport player (input req, digits, ndig, output busy, done, led);
endinterface
`default_nettype wire

// ### hdl/lis_rate_gen.sv
`timescale 1ns/1ns
`default_nettype none
module lis_rate_gen #(
	parameter int unsigned HALF_S = lis_pkg::HALF_SLOW,
	parameter int unsigned HALF_M = lis_pkg::HALF_MID,
	parameter int unsigned HALF_F = lis_pkg::HALF_FAST
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// Square wave phases
	output logic [2:0]      phase
);
	import lis_pkg::*;

	// Refuse zero half periods
	if (HALF_S < 1 || HALF_M < 1 || HALF_F < 1) begin : g_chk
		$error("lis_rate_gen: half period below one cycle");
	end

	typedef struct packed {
		logic [31:0] cs;  // Slow counter
		logic [31:0] cm;  // Mid counter
		logic [31:0] cf;  // Fast counter
		logic [2:0]  ph;  // Phases
	} lis_rate_t;

	lis_rate_t st, next_st;

	// True at the last cycle of a half period
	function automatic logic wrap(logic [31:0] c, int unsigned h);
		return c == 32'(h - 1);
	endfunction

	// Counters and phase toggles
	always_comb begin
		next_st = st;
		next_st.cs = wrap(st.cs, HALF_S) ? 32'h0 : st.cs + 32'h1;
		next_st.cm = wrap(st.cm, HALF_M) ? 32'h0 : st.cm + 32'h1;
		next_st.cf = wrap(st.cf, HALF_F) ? 32'h0 : st.cf + 32'h1;
		next_st.ph[PH_SLOW] = st.ph[PH_SLOW] ^ wrap(st.cs, HALF_S);
		next_st.ph[PH_MID]  = st.ph[PH_MID] ^ wrap(st.cm, HALF_M);
		next_st.ph[PH_FAST] = st.ph[PH_FAST] ^ wrap(st.cf, HALF_F);
	end

	// State register
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign phase = st.ph;
endmodule
`default_nettype wire

// ### hdl/lis_code_player.sv
`timescale 1ns/1ns
`default_nettype none
module lis_code_player #(
	parameter int unsigned SHORT_C = lis_pkg::SHORT_CYC,
	parameter int unsigned LONG_C  = lis_pkg::LONG_CYC,
	parameter int unsigned GAP_C   = lis_pkg::GAP_CYC
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// Code request and blink
	lis_code_if.player code
);
	import lis_pkg::*;

	// Refuse zero durations
	if (SHORT_C < 1 || LONG_C < 1 || GAP_C < 1) begin : g_chk
		$error("lis_code_player: duration below one cycle");
	end

	typedef enum logic [1:0] {P_IDLE, P_ON, P_OFF, P_GAP} lis_pst_t;

	typedef struct packed {
		lis_pst_t    ps;     // Phase of playback
		logic [15:0] dig;    // Latched digits
		logic [2:0]  ndig;   // Latched digit count
		logic [1:0]  idx;    // Current digit
		logic [2:0]  left;   // Pulses left in digit
		logic [31:0] tmr;    // Down counter
		logic        done;   // Finish pulse
	} lis_play_t;

	lis_play_t st, next_st;

	// Lit or dark length of one pulse of a digit
	function automatic logic [31:0] dur(logic [15:0] d, logic [1:0] i);
		return d[DIG_W*i + DIG_LONG] ? 32'(LONG_C - 1) : 32'(SHORT_C - 1);
	endfunction

	// Pulse count of one digit
	function automatic logic [2:0] cnt(logic [15:0] d, logic [1:0] i);
		return d[DIG_W*i +: 3];
	endfunction

	// Playback sequence
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		case (st.ps)
			P_IDLE: begin
				// Requests while busy never reach here
				if (code.req) begin
					next_st.dig  = code.digits;
					next_st.ndig = code.ndig;
					next_st.idx  = 2'h0;
					next_st.left = cnt(code.digits, 2'h0);
					next_st.tmr  = dur(code.digits, 2'h0);
					next_st.ps   = P_ON;
				end
			end
			P_ON: begin
				// Equal dark time after each lit time
				if (st.tmr == 32'h0) begin
					next_st.tmr = dur(st.dig, st.idx);
					next_st.ps  = P_OFF;
				end else begin
					next_st.tmr = st.tmr - 32'h1;
				end
			end
			P_OFF: begin
				if (st.tmr != 32'h0) begin
					next_st.tmr = st.tmr - 32'h1;
				end else if (st.left > 3'h1) begin
					// Pulses per digit equal its value
					next_st.left = st.left - 3'h1;
					next_st.tmr  = dur(st.dig, st.idx);
					next_st.ps   = P_ON;
				end else if (3'(st.idx) + 3'h1 < st.ndig) begin
					next_st.tmr = 32'(GAP_C - 1);
					next_st.ps  = P_GAP;
				end else begin
					// One emission per request
					next_st.done = 1'b1;
					next_st.ps   = P_IDLE;
				end
			end
			P_GAP: begin
				if (st.tmr == 32'h0) begin
					next_st.idx  = st.idx + 2'h1;
					next_st.left = cnt(st.dig, st.idx + 2'h1);
					next_st.tmr  = dur(st.dig, st.idx + 2'h1);
					next_st.ps   = P_ON;
				end else begin
					next_st.tmr = st.tmr - 32'h1;
				end
			end
			default: next_st.ps = P_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign code.busy = (st.ps != P_IDLE);
	assign code.done = st.done;
	assign code.led  = (st.ps == P_ON);
endmodule
`default_nettype wire

// ### verif/lis_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module lis_top_assertions #(
	parameter int unsigned SHORT_C   = lis_pkg::SHORT_CYC,
	parameter int unsigned LONG_C    = lis_pkg::LONG_CYC,
	parameter logic [7:0]  MEM_ERROR = 8'he8
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               reset_n,
	// Requests seen by the block
	input  wire logic               code_req,
	input  wire lis_pkg::lis_code_t code_sel,
	input  wire logic               progress_write,
	input  wire logic [7:0]         progress_code,
	// Outputs watched
	input  wire logic               status_green,
	input  wire logic               status_amber,
	input  wire logic               fault_blink_indicator,
	input  wire logic [7:0]         progress_leds,
	input  wire logic               code_busy,
	input  wire logic               code_done,
	input  wire logic               system_halt
);
	import lis_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic [31:0] lit_len;       // Cycles the blink output has been lit
	logic [31:0] next_lit_len;  // Next lit count
	logic [31:0] dark_len;      // Cycles the blink output has been dark
	logic [31:0] next_dark_len; // Next dark count
	// Count lit and dark cycles of the blink output
	always_comb begin
		next_lit_len  = fault_blink_indicator ? lit_len + 32'h1 : 32'h0;
		next_dark_len = fault_blink_indicator ? 32'h0 : dark_len + 32'h1;
	end
	// Register the counts; dark before reset counts as long enough
	always_ff @(posedge clk) begin
		lit_len  <= reset_n ? next_lit_len : 32'h0;
		dark_len <= reset_n ? next_dark_len : 32'(SHORT_C);
	end
	// Request that the player accepts
	sequence s_take;
		code_req && !code_busy && !code_done;
	endsequence
	// Halted with a given progress code shown
	sequence s_halt(logic [7:0] pc);
		system_halt && progress_leds == pc;
	endsequence
	chk_busy_rise: assert property (s_take |=> code_busy)
		else $error("busy missing after request");
	chk_lit_length: assert property ($fell(fault_blink_indicator) |->
		lit_len == SHORT_C || lit_len == LONG_C)
		else $error("blink lit time wrong");
	chk_dark_length: assert property ($rose(fault_blink_indicator) |->
		dark_len >= SHORT_C)
		else $error("blink dark time too short");
	chk_led_in_code: assert property (fault_blink_indicator |-> code_busy)
		else $error("blink outside a code");
	chk_done_pulse: assert property (code_done |=> !code_done && !code_busy)
		else $error("done not a single pulse");
	chk_halt_security: assert property (s_take ##0 code_sel == LIS_SECURITY
		|=> s_halt(PROG_SECURITY))
		else $error("security halt wrong");
	chk_halt_memory: assert property (s_take ##0 code_sel == LIS_MEMORY
		|=> s_halt(MEM_ERROR))
		else $error("memory halt wrong");
	chk_halt_cpu: assert property (s_take ##0 code_sel == LIS_CPU_MISMATCH
		|=> s_halt(PROG_CPU))
		else $error("cpu halt wrong");
	chk_halt_holds: assert property (system_halt |=>
		system_halt && $stable(progress_leds))
		else $error("halt state changed");
	chk_progress_load: assert property (progress_write && !system_halt &&
		!code_req |=> progress_leds == $past(progress_code))
		else $error("progress code not shown");
	chk_amber_wins: assert property (status_amber |-> !status_green)
		else $error("amber and green together");
endmodule
bind lis_top lis_top_assertions #(
	.SHORT_C  (SHORT_C),
	.LONG_C   (LONG_C),
	.MEM_ERROR(MEM_ERROR)
) u_chk (
	.clk(clk), .reset_n(reset_n), .code_req(code_req), .code_sel(code_sel),
	.progress_write(progress_write), .progress_code(progress_code),
	.status_green(status_green), .status_amber(status_amber),
	.fault_blink_indicator(fault_blink_indicator),
	.progress_leds(progress_leds), .code_busy(code_busy),
	.code_done(code_done), .system_halt(system_halt)
);
`default_nettype wire

// ### verif/lis_fw_model.sv
`timescale 1ns/1ns
`default_nettype none
module lis_fw_model (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                reset_n,
	// Bench command
	input  wire logic                go,
	input  wire lis_pkg::lis_code_t  sel,
	output logic                     idle,
	// Block side
	output logic                     code_req,
	output var lis_pkg::lis_code_t   code_sel,
	input  wire logic                code_done
);
	import lis_pkg::*;
	logic wait_done; // Code in flight
	// Free only with nothing requested or playing
	assign idle = !wait_done && !code_req;
	// One request, then hold off until the code is done
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			code_req <= 1'b0;
			wait_done <= 1'b0;
			code_sel <= LIS_USB;
		end else begin
			code_req <= go && idle;
			if (go && idle) begin
				code_sel <= sel;
				wait_done <= 1'b1;
			end else if (code_done) begin
				wait_done <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	import lis_pkg::*;
	localparam int unsigned SC   = 2;     // Short lit time
	localparam int unsigned LC   = 4;     // Long lit time
	localparam int unsigned HS   = 4;     // Slow half period
	localparam int unsigned HM   = 3;     // Mid half period
	localparam int unsigned HF   = 2;     // Fast half period
	localparam logic [7:0]  MEMC = 8'h9c; // Memory halt code used here
	localparam int          LIM  = 400;   // Bound on every wait
	// Expected result per code: {long pulses, digit string}
	localparam logic [19:0] TAB [12] = '{20'h00001, 20'h10001, 20'h00003,
		20'h30031, 20'h00002, 20'h00004, 20'h01521, 20'h01524, 20'h01542,
		20'h01544, 20'h01512, 20'h01514};
	// Progress code expected after each halt
	localparam logic [7:0]  HP [4] = '{8'h00, PROG_SECURITY, MEMC, PROG_CPU};
	logic        clk, reset_n, go, idle, code_req, health_degraded;
	logic        health_fault, progress_write, self_test_complete;
	logic [7:0]  ev, progress_code, progress_leds, p;
	logic        identify_led, status_green, status_amber, code_busy;
	logic        fault_blink_indicator, code_done, system_halt;
	lis_code_t   code_sel, sel;
	logic [19:0] q[$];           // Expected code results, oldest first
	logic [15:0] acc;            // Digit string seen so far
	int          n_fail, n_compared, hi, lo, dig, nlong, i;
	// Block under test with short counts
	lis_top #(.HALF_S(HS), .HALF_M(HM), .HALF_F(HF), .SHORT_C(SC),
		.LONG_C(LC), .GAP_C(6), .MEM_ERROR(MEMC)) dut (
		.clk(clk), .reset_n(reset_n), .identify_button(ev[0]),
		.remote_identify_on(ev[1]), .remote_identify_off(ev[2]),
		.mc_reset_start(ev[3]), .mc_mem_test_fail(ev[4]),
		.mc_images_bad(ev[5]), .mc_os_handoff(ev[6]), .mc_boot_done(ev[7]),
		.health_degraded(health_degraded), .health_fault(health_fault),
		.code_req(code_req), .code_sel(code_sel),
		.progress_write(progress_write), .progress_code(progress_code),
		.self_test_complete(self_test_complete), .identify_led(identify_led),
		.status_green(status_green), .status_amber(status_amber),
		.fault_blink_indicator(fault_blink_indicator),
		.progress_leds(progress_leds), .code_busy(code_busy),
		.code_done(code_done), .system_halt(system_halt));
	// Firmware side issuing fault codes
	lis_fw_model fw (.clk(clk), .reset_n(reset_n), .go(go), .sel(sel),
		.idle(idle), .code_req(code_req), .code_sel(code_sel),
		.code_done(code_done));
	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Pass edges, then settle just after the last one
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	// One-cycle pulse on an event input
	task automatic pul(input int k);
		ev[k] = 1'b1;
		tick(1);
		ev[k] = 1'b0;
	endtask
	// Compare and count
	task automatic chk(input string nm, input logic [19:0] e,
		input logic [19:0] g);
		n_compared++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask
	// A used-up wait ends the run
	task automatic stop_if(input int n);
		if (n >= LIM) begin
			n_fail++;
			report_and_stop();
		end
	endtask
	task automatic rst();
		reset_n = 1'b0;
		tick(2);
		reset_n = 1'b1;
	endtask
	function automatic logic pick(input int w);
		return w ? status_green : identify_led;
	endfunction
	// Half period of a LED; the first two spans may be cut short
	task automatic period(input int w, input int e);
		int n;
		logic v;
		repeat (3) begin
			v = pick(w);
			n = 0;
			while (pick(w) === v && n < LIM) begin
				tick(1);
				n++;
			end
			stop_if(n);
		end
		chk("half period", 20'(e), 20'(n));
	endtask
	// Note the expected result, then let firmware request the code
	task automatic code(input int k);
		int n;
		q.push_back(TAB[k]);
		sel = lis_code_t'(k);
		go = 1'b1;
		tick(1);
		go = 1'b0;
		n = 0;
		while (idle !== 1'b1 && n < LIM) begin
			tick(1);
			n++;
		end
		stop_if(n);
	endtask
	task automatic report_and_stop();
		if (n_fail == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Decode blink groups; a long dark ends a digit
	always @(negedge clk) begin
		if (fault_blink_indicator === 1'b1) begin
			if (lo > LC) begin
				acc = {acc[11:0], 4'(dig)};
				dig = 0;
			end
			hi++;
			lo = 0;
		end else begin
			if (hi > 0) dig++;
			if (hi > SC) nlong++;
			hi = 0;
			lo++;
		end
		if (code_done === 1'b1) begin
			acc = {acc[11:0], 4'(dig)};
			chk("code", q.size() > 0 ? q.pop_front() : 20'hfffff,
				{4'(nlong), acc});
			acc = 16'h0000;
			dig = 0;
			nlong = 0;
		end
	end
	// Main sequence
	initial begin
		{reset_n, go, health_degraded, health_fault} = 4'h0;
		{progress_write, self_test_complete} = 2'b00;
		{ev, progress_code, acc} = 32'h0;
		{n_fail, n_compared, hi, lo, dig, nlong} = 192'h0;
		sel = LIS_USB;
		void'($urandom(32'h8c4d));
		rst();
		chk("halt", 0, system_halt);
		period(0, HM);
		period(1, HS);
		pul(5);
		tick(2);
		chk("amber", 1, status_amber);
		period(0, HF);
		rst();
		pul(4);
		tick(2);
		chk("id", 1, identify_led);
		chk("amber", 1, status_amber);
		rst();
		progress_write = 1'b1;
		repeat (3) begin
			p = 8'($urandom);
			progress_code = p;
			tick(1);
			chk("progress", p, progress_leds);
		end
		progress_write = 1'b0;
		self_test_complete = 1'b1;
		tick(1);
		self_test_complete = 1'b0;
		chk("progress", 0, progress_leds);
		pul(6);
		tick(2);
		chk("id", 1, identify_led);
		chk("green", 1, status_green);
		pul(7);
		tick(2);
		chk("id", 0, identify_led);
		chk("green", 1, status_green);
		pul(0);
		tick(2);
		chk("id", 1, identify_led);
		tick(3 * HS);
		chk("id", 1, identify_led);
		pul(1);
		period(0, HS);
		pul(0);
		tick(2);
		chk("id", 1, identify_led);
		pul(0);
		tick(2);
		chk("id", 0, identify_led);
		pul(1);
		pul(2);
		tick(HS + 1);
		chk("id", 0, identify_led);
		health_degraded = 1'b1;
		period(1, HS);
		health_fault = 1'b1;
		tick(2);
		chk("amber", 1, status_amber);
		chk("green", 0, status_green);
		{health_fault, health_degraded} = 2'b00;
		pul(3);
		tick(2);
		period(0, HM);
		for (i = 0; i < 12; i++) begin
			if (i > 3 || i == 0) code(i);
		end
		for (i = 1; i < 4; i++) begin
			code(i);
			chk("halt", 1, system_halt);
			progress_code = 8'h5a;
			progress_write = 1'b1;
			tick(1);
			progress_write = 1'b0;
			chk("progress", HP[i], progress_leds);
			rst();
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
